// [test/ldc_host_model.sv]
// Purpose: controller that writes frames on the two serial lines
// Assumes: serial clock half period 40 ns, lines pulled up
// Notes:   clock stands high between frames
`timescale 1ns/1ps
module ldc_host_model (
  output logic sda,
  output logic sck
);
  initial
  begin
    sda = 1'b1;
    sck = 1'b1;
  end
  task automatic send(input logic [10:0] word, input int nb);
    int i;
    sda = 1'b0;
    #40;
    for (i = 10; i > 10 - nb; i--)
    begin
      sck = 1'b0;
      #10 sda = word[i];
      #30 sck = 1'b1;
      #40;
    end
    sck = 1'b0;
    #10 sda = 1'b0;
    #30 sck = 1'b1;
    #40 sda = 1'b1;
    #80;
  endtask
  // frame cut short; a fresh start must follow
  task automatic lead(input logic [10:0] word, input int nb);
    int i;
    sda = 1'b0;
    #40;
    for (i = 10; i > 10 - nb; i--)
    begin
      sck = 1'b0;
      #10 sda = word[i];
      #30 sck = 1'b1;
      #40;
    end
    // raise data under a low clock so no stop is seen
    sck = 1'b0;
    #10 sda = 1'b1;
    #30 sck = 1'b1;
    #40;
  endtask
endmodule // ldc_host_model

// [test/ldc_serial_control_props.sv]
// Purpose: port checks for the serial control block
// Assumes: one clk domain, synchronous active-low reset
// Notes:   pin-to-output figures allow for the two sync stages
`timescale 1ns/1ps
module ldc_serial_control_props
  import ldc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       sdaPin,
  input wire logic       sckPin,
  input wire logic       shutdownPin,
  input wire logic       faultCondition,
  input wire ldc_ctrl_s  controlFlags,
  input wire logic       equalizerOn,
  input wire logic [7:0] equalizerStrength,
  input wire logic [7:0] modulationLevelCode,
  input wire logic       modulationRangeSelect,
  input wire logic       modulationOn,
  input wire logic [7:0] biasLevelCode,
  input wire logic       biasOn,
  input wire logic       faultOutput,
  input wire logic       ignoredWrite
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence shut_held;
    shutdownPin[*4];
  endsequence
  sequence fault_armed;
    (faultCondition && controlFlags.faultDetectOn)[*4];
  endsequence
  // seven low samples leave no room for a stop latency
  sequence no_stop;
    (!sdaPin)[*7];
  endsequence
  sequence stop_cond;
    (sckPin && !sdaPin) ##1 (sckPin && sdaPin);
  endsequence
  ////////////////////////////////////////////////////////////
  chk_eq_path: assert property ($stable(controlFlags)[*3] |-> equalizerOn == !controlFlags.equalizerBypass)
    else $error("equalizer path disagrees with bypass bit");
  chk_range_copy: assert property ($stable(controlFlags)[*3] |-> modulationRangeSelect == controlFlags.modulationRangeSelect)
    else $error("range select disagrees with control");
  chk_shut_off: assert property (shut_held |-> !modulationOn && !biasOn)
    else $error("modulation on during shutdown");
  chk_chip_gate: assert property ((!controlFlags.chipOn)[*3] |-> !modulationOn && !faultOutput)
    else $error("output active with chip off");
  chk_fault_off: assert property (fault_armed |-> !modulationOn)
    else $error("modulation on during armed fault");
  chk_regs_hold: assert property (no_stop |-> $stable(biasLevelCode) && $stable(modulationLevelCode) && $stable(equalizerStrength))
    else $error("register changed without stop");
  chk_ign_pulse: assert property (ignoredWrite |=> !ignoredWrite)
    else $error("ignored write pulse too long");
  chk_ign_keeps: assert property (ignoredWrite |-> $stable(controlFlags) && $stable(modulationLevelCode) && $stable(biasLevelCode) && $stable(equalizerStrength))
    else $error("unmapped write changed a register");
  cover property (stop_cond);
endmodule // ldc_serial_control_props

bind ldc_serial_control ldc_serial_control_props u_props (
  .clk(clk), .rst_b(rst_b), .sdaPin(sdaPin), .sckPin(sckPin), .shutdownPin(shutdownPin),
  .faultCondition(faultCondition), .controlFlags(controlFlags), .equalizerOn(equalizerOn),
  .equalizerStrength(equalizerStrength), .modulationLevelCode(modulationLevelCode),
  .modulationRangeSelect(modulationRangeSelect), .modulationOn(modulationOn),
  .biasLevelCode(biasLevelCode), .biasOn(biasOn), .faultOutput(faultOutput), .ignoredWrite(ignoredWrite)
);

// [test/tb.sv]
// Purpose: self-checking bench for the serial control block
// Assumes: host model drives the serial pins
// Notes:   expected registers kept in a local array
`timescale 1ns/1ps
module tb;
  import ldc_pkg::*;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       shutdownPin = 1'b0;
  logic       faultCondition = 1'b0;
  wire        sdaPin;
  wire        sckPin;
  ldc_ctrl_s  ctrl;
  logic       eqOn, modRange, modOn, biasOn, fltOut, ignWr;
  logic [7:0] eqStr, modCode, biasCode;
  logic [7:0] regs [4];
  int         err_count = 0;
  int         n_compared = 0;
  int         ignSeen = 0;
  int         ignExp = 0;
  int         i;
  always #5 clk = ~clk;
  always @(posedge clk) if (ignWr === 1'b1) ignSeen++;
  ldc_host_model host (.sda(sdaPin), .sck(sckPin));
  ldc_serial_control uut (
    .clk(clk), .rst_b(rst_b), .sdaPin(sdaPin), .sckPin(sckPin), .shutdownPin(shutdownPin),
    .faultCondition(faultCondition), .controlFlags(ctrl), .equalizerOn(eqOn), .equalizerStrength(eqStr),
    .modulationLevelCode(modCode), .modulationRangeSelect(modRange), .modulationOn(modOn),
    .biasLevelCode(biasCode), .biasOn(biasOn), .faultOutput(fltOut), .ignoredWrite(ignWr)
  );
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // short frames leave the model untouched
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input int nb);
    host.send({a, d}, nb);
    if (nb == 11 && a < 3'h4) regs[a[1:0]] = d;
    if (nb == 11 && a >= 3'h4) ignExp++;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic fault_output);
    logic on;
    on = regs[0][7] & ~shutdownPin & ~fault_output;
    cmp({ctrl, modCode, biasCode, eqStr}, {regs[0], regs[1], regs[2], regs[3]});
    cmp(32'({eqOn, modRange, modOn, biasOn, fltOut}), 32'({~regs[0][1], regs[0][2], on, on, fault_output}));
  endtask
  task automatic pins(input logic s, input logic f);
    @(posedge clk);
    #1;
    shutdownPin = s;
    faultCondition = f;
    repeat (6) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(70537));
    regs = '{default: 8'h00};
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(1'b0);
    $display("test reset done");
    wr(3'h2, 8'($urandom), 11);
    wr(3'h1, 8'($urandom), 11);
    wr(3'h0, 8'h80, 11);
    check(1'b0);
    for (i = 0; i < 16; i++)
    begin
      wr(i[2:0], 8'($urandom), 11);
      check(1'b0);
    end
    cmp(32'(ignSeen), 32'(ignExp));
    $display("test random writes done");
    wr(3'h3, ~regs[3], 10);
    check(1'b0);
    $display("test short frame done");
    host.lead({3'h1, 8'($urandom)}, 5);
    wr(3'h2, 8'($urandom), 11);
    check(1'b0);
    $display("test restart done");
    wr(3'h0, 8'h80, 11);
    pins(1'b1, 1'b0);
    check(1'b0);
    pins(1'b0, 1'b0);
    check(1'b0);
    $display("test shutdown done");
    wr(3'h0, 8'h88, 11);
    pins(1'b0, 1'b1);
    check(1'b1);
    wr(3'h0, 8'h08, 11);
    check(1'b0);
    pins(1'b0, 1'b0);
    wr(3'h0, 8'h88, 11);
    check(1'b0);
    wr(3'h0, 8'h80, 11);
    pins(1'b0, 1'b1);
    check(1'b0);
    $display("test fault done");
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    regs = '{default: 8'h00};
    repeat (4) @(posedge clk);
    #1;
    check(1'b0);
    $display("test mid-run reset done");
    finish_test();
  end
  initial
  begin
    #300000;
    err_count++;
    finish_test();
  end
endmodule // tb

// [verilog/ldc_decode.sv]
// Purpose: 3-to-8 one-hot address decoder
// Assumes: purely combinational, same clock as the caller
// Notes:   every address gets its own select line
`timescale 1ns/1ps
module ldc_decode
  import ldc_pkg::*;
(
  input  wire logic [ADDR_BITS-1:0] addr,
  output logic      [SEL_COUNT-1:0] select
);

  function automatic logic [SEL_COUNT-1:0] one_hot(input logic [ADDR_BITS-1:0] a);
    logic [SEL_COUNT-1:0] r;
    r    = '0;
    r[a] = 1'b1;
    return r;
  endfunction

  assign select = one_hot(addr);

endmodule // ldc_decode

// [verilog/ldc_pkg.sv]
// Purpose: shared constants and types for the laser driver serial control port
// Assumes: 3 address bits and 8 data bits per write, four implemented registers
// Notes:   everything here except the POS_ field positions is consumed by ldc_serial_control and its leaves
package ldc_pkg;

  localparam int unsigned ADDR_BITS  = 3;
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned SHIFT_BITS = ADDR_BITS + DATA_BITS;
  localparam int unsigned REG_COUNT  = 4;
  localparam int unsigned SEL_COUNT  = 8;

  // register addresses
  localparam logic [2:0] ADDR_CONTROL_FLAGS   = 3'h0;
  localparam logic [2:0] ADDR_MODULATION      = 3'h1;
  localparam logic [2:0] ADDR_BIAS            = 3'h2;
  localparam logic [2:0] ADDR_EQUALIZER       = 3'h3;

  // field positions inside control_flags
  localparam int unsigned POS_CHIP_ON         = 7;
  localparam int unsigned POS_PD_POLARITY     = 6;
  localparam int unsigned POS_PD_RANGE        = 5;
  localparam int unsigned POS_OPEN_LOOP       = 4;
  localparam int unsigned POS_FAULT_DETECT_ON = 3;
  localparam int unsigned POS_MOD_RANGE       = 2;
  localparam int unsigned POS_EQ_BYPASS       = 1;

  // values after power-on, and bit count limits
  localparam logic [7:0] REG_RESET            = 8'h00;
  localparam logic [3:0] COUNT_RESET          = 4'h0;
  localparam logic [3:0] COUNT_FULL           = 4'hB;
  localparam logic [3:0] COUNT_STOP           = 4'hC;
  localparam logic [3:0] COUNT_SAT            = 4'hF;

  // control_flags layout, bit 7 first
  typedef struct packed {
    logic chipOn;
    logic photodiodePolarity;
    logic photodiodeRange;
    logic openLoopSelect;
    logic faultDetectOn;
    logic modulationRangeSelect;
    logic equalizerBypass;
    logic unused;
  } ldc_ctrl_s;

  // levels seen on the serial and status pins after synchronising
  typedef struct packed {
    logic fault;
    logic shutdown;
    logic sck;
    logic sda;
  } ldc_pins_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } ldc_state_e;

endpackage

// [verilog/ldc_serial_control.sv]
// Purpose: write-only two-wire control port and register bank of a laser driver
// Assumes: clk at 100 MHz, serial lines and status pins asynchronous to it
// Notes:   serial clock is sampled, not used as a clock
//
// Notes on behaviour
// - equalizer bypass bit 1 of control at 0 routes data through equalizer.
// - equalizer bypass at 1 switches equalizer off and bypasses it.
// - equalizer strength comes from the 8-bit code in register 3.
// - 8-bit modulation level code goes to the modulation current generator.
// - one range-select bit picks between two modulation current ranges.
// - modulation generator runs only while chip-on is set.
// - shutdown pin high forces modulation current off.
// - fault present with fault detect enabled forces modulation off.
// - both lines high means idle on both sides.
// - start is data falling while serial clock high.
// - bits are captured while serial clock is high into 11-bit shift register.
// - stop is data rising after serial clock went high.
// - on stop the eight data bits go into the addressed register.
// - three address bits decode into eight select lines.
// - only addresses 0 to 3 hold registers.
// - control layout from bit 7: chip-on, pd polarity, pd range, open loop, fault en, mod range, eq bypass.
// - register 1 holds the full modulation level code.
// - register 2 holds the full bias level code.
// - register 3 holds the full equalizer strength code.
// - all control registers clear to zero at power-on.
// - toggling chip-on low then high releases the latched fault.
// - disabling by chip-on or shutdown keeps register contents.
`timescale 1ns/1ps
module ldc_serial_control
  import ldc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       sdaPin,
  input  wire logic       sckPin,
  input  wire logic       shutdownPin,
  input  wire logic       faultCondition,
  output ldc_ctrl_s       controlFlags,
  output logic            equalizerOn,
  output logic      [7:0] equalizerStrength,
  output logic      [7:0] modulationLevelCode,
  output logic            modulationRangeSelect,
  output logic            modulationOn,
  output logic      [7:0] biasLevelCode,
  output logic            biasOn,
  output logic            faultOutput,
  output logic            ignoredWrite
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  ldc_pins_s pinsRaw;
  ldc_pins_s pinsSync;

  assign pinsRaw.sda      = sdaPin;
  assign pinsRaw.sck      = sckPin;
  assign pinsRaw.shutdown = shutdownPin;
  assign pinsRaw.fault    = faultCondition;

  ldc_sync #(
    .WIDTH   (4)
  ) u_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn (pinsRaw),
    .syncOut (pinsSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // condition detection

  logic sdaPrev;
  logic sckPrev;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sdaPrev <= 1'b1;
      sckPrev <= 1'b1;
    end
    else
    begin
      sdaPrev <= pinsSync.sda;
      sckPrev <= pinsSync.sck;
    end
  end

  wire sckHigh   = pinsSync.sck & sckPrev;
  wire startSeen = sckHigh & sdaPrev & ~pinsSync.sda;
  wire stopSeen  = sckHigh & ~sdaPrev & pinsSync.sda;
  // sample on entry to high phase
  wire sckRise   = pinsSync.sck & ~sckPrev;

  ////////////////////////////////////////////////////////////////////////////
  // shift engine

  ldc_state_e            state;
  ldc_state_e            next_state;
  logic [SHIFT_BITS-1:0] shiftReg;
  logic [SHIFT_BITS-1:0] next_shiftReg;
  logic [3:0]            bitCount;
  logic [3:0]            next_bitCount;
  logic                  commit;

  // stop clock rise is counted but never shifted, so a 10-bit frame cannot pass as 11
  wire countFull = (bitCount >= COUNT_FULL);
  wire countStop = (bitCount == COUNT_STOP);
  // saturate so an overlong frame cannot wrap back to a valid count
  wire countSat  = (bitCount == COUNT_SAT);

  always_comb
  begin
    next_state    = state;
    next_shiftReg = shiftReg;
    next_bitCount = bitCount;
    commit        = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (startSeen)
        begin
          next_state    = ST_SHIFT;
          next_bitCount = COUNT_RESET;
        end
      end
      ST_SHIFT:
      begin
        if (startSeen)
        begin
          next_bitCount = COUNT_RESET;
        end
        else if (stopSeen)
        begin
          commit     = countStop;
          next_state = ST_IDLE;
        end
        else if (sckRise && !countSat)
        begin
          // stop clock edge is counted only
          if (!countFull)
          begin
            next_shiftReg = {shiftReg[SHIFT_BITS-2:0], pinsSync.sda};
          end
          next_bitCount = bitCount + 4'h1;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state    <= ST_IDLE;
      shiftReg <= '0;
      bitCount <= COUNT_RESET;
    end
    else
    begin
      state    <= next_state;
      shiftReg <= next_shiftReg;
      bitCount <= next_bitCount;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode and register bank

  logic [SEL_COUNT-1:0] select;
  logic [7:0]           regBank [REG_COUNT];

  wire [ADDR_BITS-1:0] shiftAddr = shiftReg[SHIFT_BITS-1:DATA_BITS];
  wire [DATA_BITS-1:0] shiftData = shiftReg[DATA_BITS-1:0];

  // bank index is two bits wide; addresses 4..7 never reach it
  wire [1:0] idxControl    = ADDR_CONTROL_FLAGS[1:0];
  wire [1:0] idxModulation = ADDR_MODULATION[1:0];
  wire [1:0] idxBias       = ADDR_BIAS[1:0];
  wire [1:0] idxEqualizer  = ADDR_EQUALIZER[1:0];

  ldc_decode u_decode (
    .addr   (shiftAddr),
    .select (select)
  );

  wire upperHit = |select[SEL_COUNT-1:REG_COUNT];

  genvar r;
  generate
    for (r = 0; r < REG_COUNT; r++)
    begin : g_reg
      // contents held regardless of enable state
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          regBank[r] <= REG_RESET;
        end
        else if (commit && select[r])
        begin
          regBank[r] <= shiftData;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // fault latch and output gating

  ldc_ctrl_s ctrlNow;
  logic      faultLatch;
  logic      next_faultLatch;

  assign ctrlNow = ldc_ctrl_s'(regBank[idxControl]);

  // fault pin is sampled, so a pulse shorter than a clk period may be missed

  wire disabledNow = ~ctrlNow.chipOn | pinsSync.shutdown;
  wire faultHit    = pinsSync.fault & ctrlNow.faultDetectOn;

  // clear wins while disabled, as the part releases the pin then
  assign next_faultLatch = disabledNow ? 1'b0 : (faultLatch | faultHit);

  wire next_modulationOn = ~disabledNow & ~next_faultLatch;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      faultLatch <= 1'b0;
    end
    else
    begin
      faultLatch <= next_faultLatch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      controlFlags          <= ldc_ctrl_s'(REG_RESET);
      equalizerOn           <= 1'b0;
      equalizerStrength     <= REG_RESET;
      modulationLevelCode   <= REG_RESET;
      modulationRangeSelect <= 1'b0;
      modulationOn          <= 1'b0;
      biasLevelCode         <= REG_RESET;
      biasOn                <= 1'b0;
      faultOutput           <= 1'b0;
      ignoredWrite          <= 1'b0;
    end
    else
    begin
      controlFlags          <= ctrlNow;
      equalizerOn           <= ~ctrlNow.equalizerBypass;
      equalizerStrength     <= regBank[idxEqualizer];
      modulationLevelCode   <= regBank[idxModulation];
      modulationRangeSelect <= ctrlNow.modulationRangeSelect;
      modulationOn          <= next_modulationOn;
      biasLevelCode         <= regBank[idxBias];
      // bias also drops to zero on a latched fault
      biasOn                <= ~disabledNow & ~next_faultLatch;
      faultOutput           <= next_faultLatch;
      // completed write to 4..7 stores nothing
      ignoredWrite          <= commit & upperHit;
    end
  end

endmodule // ldc_serial_control

// [verilog/ldc_sync.sv]
// Purpose: two-flop synchroniser for a group of asynchronous pin levels
// Assumes: inputs are slow levels compared with clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module ldc_sync
  import ldc_pkg::*;
#(
  parameter int unsigned WIDTH = 4
)
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // idle lines are high, so resetting to one avoids a false edge
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          stage1[i]  <= 1'b1;
          syncOut[i] <= 1'b1;
        end
        else
        begin
          stage1[i]  <= asyncIn[i];
          syncOut[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule // ldc_sync
